// [src/tcc_pkg.sv]
/*
 * tcc_pkg: register map, field positions, reset values and mode
 * encodings for the channel 4 register A capture/compare block.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package tcc_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam int SEL_W = 8;

	localparam logic [ADDR_W-1:0] OFS_IO_SELECT = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_GEN_REG_A = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BUFFER = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

	// io select field positions
	localparam int SEL_BIT0 = 0;
	localparam int SEL_BIT1 = 1;
	localparam int SEL_BIT2 = 2;
	localparam int SEL_BIT3 = 3;

	// control and status field positions
	localparam int CTL_BUF_EN = 0;
	localparam int STS_CAP_FLAG = 0;
	localparam int STS_PIN_OUT = 1;
	localparam int STS_PIN_IN = 2;

	localparam logic [SEL_W-1:0] RST_IO_SELECT = 8'h00;
	localparam logic [CNT_W-1:0] RST_GEN_REG_A = 16'hFFFF;
	localparam logic [CNT_W-1:0] RST_BUFFER = 16'hFFFF;
	localparam logic RST_BUF_EN = 1'b0;
	localparam logic RST_PIN_LEVEL = 1'b0;

	// low two select bits in output compare function
	localparam logic [1:0] OC_DISABLED = 2'h0;
	localparam logic [1:0] OC_LOW = 2'h1;
	localparam logic [1:0] OC_HIGH = 2'h2;
	localparam logic [1:0] OC_TOGGLE = 2'h3;

	typedef enum {CAP_RISE, CAP_FALL, CAP_BOTH, CAP_CH3} tcc_cap_src_t;
endpackage : tcc_pkg

// [src/tcc_store_if.sv]
/*
 * tcc_store_if: carries capture events, bus writes and stored values
 * between the control logic and the register A storage.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
interface tcc_store_if;
	import tcc_pkg::*;
	logic cap_evt;
	logic wr_gra;
	logic wr_buf;
	logic buf_en;
	logic [CNT_W-1:0] wdata;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] gra;
	logic [CNT_W-1:0] buf_val;

	modport ctrl (
		output cap_evt, wr_gra, wr_buf, buf_en, wdata, count,
		input gra, buf_val
	);
	modport store (
		input cap_evt, wr_gra, wr_buf, buf_en, wdata, count,
		output gra, buf_val
	);
endinterface : tcc_store_if

// [src/tcc_edge.sv]
/*
 * tcc_edge: two-flop synchroniser for the capture pin plus edge
 * detection on consecutive synchronised samples.
 * Assumes pin_in is asynchronous to pclk.
 */
`timescale 1ns/1ps
module tcc_edge (
	input wire logic pclk, // peripheral clock
	input wire logic presetn, // async reset, active low
	input wire logic pin_in, // raw pin level
	output logic level, // synchronised level
	output logic rise, // one-cycle pulse per rising edge
	output logic fall // one-cycle pulse per falling edge
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// first flop feeds only the second one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg; // [R11]
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~prev_reg; // [R11]
	assign fall = ~sync_reg & prev_reg; // [R11]
endmodule : tcc_edge

// [src/tcc_store.sv]
/*
 * tcc_store: general register A and its buffer register, with the
 * priority between bus writes and capture events.
 * Assumes write strobes mark the single commit edge of a bus write.
 */
`timescale 1ns/1ps
module tcc_store (
	input wire logic pclk, // peripheral clock
	input wire logic presetn, // async reset, active low
	tcc_store_if.store st // events, writes and stored values
);
	import tcc_pkg::*;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.gra <= RST_GEN_REG_A;
		end else if (st.cap_evt) begin
			st.gra <= st.count; // [R9]
		end else if (st.wr_gra) begin
			st.gra <= st.wdata;
		end
	end

	// in buffer mode the old capture value moves down on each capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.buf_val <= RST_BUFFER;
		end else if (st.cap_evt && st.buf_en) begin
			st.buf_val <= st.gra; // [R10]
		end else if (st.wr_buf) begin
			st.buf_val <= st.wdata;
		end
	end
endmodule : tcc_store

// [src/tcc_top.sv]
/*
 * tcc_top: channel 4 register A pin-function selection, output
 * compare pin drive, input capture source selection and APB registers.
 * Assumes counter value, compare match and channel 3 event come from
 * timer logic on pclk; the pin input is asynchronous.
 */
// Decided for this implementation: the APB slave port and the address map.
// Function
// [R1] top select bit 0: compare register; code 01 drives low, 00 disables.
// [R2] compare code 10 drives the pin high on each match.
// [R3] compare code 11 toggles the pin on each match.
// [R4] select bit 2 gives the initial pin level when output enabled.
// [R5] select 1000 captures the counter on a rising pin edge.
// [R6] select 1001 captures on a falling pin edge.
// [R7] select bits 3..1 equal 101 capture on both pin edges.
// [R8] top bits 11 capture on channel 3 register A events.
// [R9] a capture in the write commit cycle beats the register A write.
// [R10] a capture in the write commit cycle beats the buffer write.
// [R11] pin is synchronised; one edge gives exactly one capture event.
`timescale 1ns/1ps
module tcc_top (
	input wire logic pclk, // peripheral clock, 40 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [tcc_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic [tcc_pkg::CNT_W-1:0] count_value, // timer counter
	input wire logic compare_match, // match pulse on register A
	input wire logic ch3_event, // ch3 register A match/capture pulse
	input wire logic pin_in, // capture/compare pin input
	output logic pin_out, // capture/compare pin output level
	output logic pin_oe // pin output enable, high while driving
);
	import tcc_pkg::*;

	tcc_store_if st ();

	logic [SEL_W-1:0] sel_reg;
	logic buf_en_reg;
	logic cap_flag_reg;
	logic pin_level_reg;
	logic pin_oe_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic pin_sync;
	logic pin_rise;
	logic pin_fall;
	logic acc_first;
	logic commit;
	logic wr_sel;
	logic [31:0] rd_word;
	logic cap_evt;
	tcc_cap_src_t cap_src;

	// true when the select value makes register A drive the pin
	function automatic logic oc_drives(input logic [SEL_W-1:0] s);
		oc_drives = !s[SEL_BIT3] && (s[SEL_BIT1:SEL_BIT0] != OC_DISABLED);
	endfunction : oc_drives

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == OFS_IO_SELECT) || (a == OFS_GEN_REG_A) ||
			(a == OFS_BUFFER) || (a == OFS_CONTROL) ||
			(a == OFS_STATUS);
	endfunction : mapped

	// a register write takes effect at the commit edge only
	function automatic logic wr_hit(input logic c, input logic w,
			input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		wr_hit = c && w && (a == ofs);
	endfunction : wr_hit

	tcc_edge u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_in),
		.level(pin_sync),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	tcc_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.st(st)
	);

	// one wait state keeps every bus output on a flop
	assign acc_first = psel && penable && !pready_reg;
	assign commit = psel && penable && pready_reg;
	assign wr_sel = wr_hit(commit, pwrite, paddr, OFS_IO_SELECT);

	always_comb begin
		if (sel_reg[SEL_BIT2] && sel_reg[SEL_BIT3]) begin
			cap_src = CAP_CH3; // [R8]
		end else if (sel_reg[SEL_BIT1]) begin
			cap_src = CAP_BOTH; // [R7]
		end else if (sel_reg[SEL_BIT0]) begin
			cap_src = CAP_FALL; // [R6]
		end else begin
			cap_src = CAP_RISE; // [R5]
		end
	end

	always_comb begin
		cap_evt = 1'b0;
		if (sel_reg[SEL_BIT3]) begin
			case (cap_src)
				CAP_RISE: cap_evt = pin_rise; // [R5]
				CAP_FALL: cap_evt = pin_fall; // [R6]
				CAP_BOTH: cap_evt = pin_rise | pin_fall; // [R7]
				CAP_CH3: cap_evt = ch3_event; // [R8]
				default: cap_evt = 1'b0;
			endcase
		end
	end

	assign st.cap_evt = cap_evt;
	assign st.wr_gra = wr_hit(commit, pwrite, paddr, OFS_GEN_REG_A);
	assign st.wr_buf = wr_hit(commit, pwrite, paddr, OFS_BUFFER);
	assign st.buf_en = buf_en_reg;
	assign st.wdata = pwdata[CNT_W-1:0];
	assign st.count = count_value;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= RST_IO_SELECT;
		end else if (wr_sel) begin
			sel_reg <= pwdata[SEL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_en_reg <= RST_BUF_EN;
		end else if (wr_hit(commit, pwrite, paddr, OFS_CONTROL)) begin
			buf_en_reg <= pwdata[CTL_BUF_EN];
		end
	end

	// hardware set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_flag_reg <= 1'b0;
		end else if (cap_evt) begin
			cap_flag_reg <= 1'b1;
		end else if (wr_hit(commit, pwrite, paddr, OFS_STATUS) &&
				pwdata[STS_CAP_FLAG]) begin
			cap_flag_reg <= 1'b0;
		end
	end

	// a select write loads the initial level; a match in that same
	// cycle is lost because the new mode is not yet in force
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_level_reg <= RST_PIN_LEVEL;
		end else if (wr_sel) begin
			if (oc_drives(pwdata[SEL_W-1:0])) begin
				pin_level_reg <= pwdata[SEL_BIT2]; // [R4]
			end
		end else if (oc_drives(sel_reg) && compare_match) begin
			case (sel_reg[SEL_BIT1:SEL_BIT0])
				OC_LOW: pin_level_reg <= 1'b0; // [R1]
				OC_HIGH: pin_level_reg <= 1'b1; // [R2]
				OC_TOGGLE: pin_level_reg <= ~pin_level_reg; // [R3]
				default: pin_level_reg <= pin_level_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_oe_reg <= 1'b0;
		end else if (wr_sel) begin
			pin_oe_reg <= oc_drives(pwdata[SEL_W-1:0]); // [R1]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= acc_first;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= acc_first && !mapped(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (acc_first && !pwrite) begin
			prdata_reg <= rd_word;
		end
	end

	// unmapped offsets and unused bits read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (paddr == OFS_IO_SELECT) begin
			rd_word[SEL_W-1:0] = sel_reg;
		end else if (paddr == OFS_GEN_REG_A) begin
			rd_word[CNT_W-1:0] = st.gra;
		end else if (paddr == OFS_BUFFER) begin
			rd_word[CNT_W-1:0] = st.buf_val;
		end else if (paddr == OFS_CONTROL) begin
			rd_word[CTL_BUF_EN] = buf_en_reg;
		end else if (paddr == OFS_STATUS) begin
			rd_word[STS_CAP_FLAG] = cap_flag_reg;
			rd_word[STS_PIN_OUT] = pin_level_reg;
			rd_word[STS_PIN_IN] = pin_sync;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_out = pin_level_reg;
	assign pin_oe = pin_oe_reg;
endmodule : tcc_top

// [verif/tcc_pin_model.sv]
/* tcc_pin_model: far end of the ch4 register A pin.
 * Assumes the bench sets ext_level while the block does not drive. */
`timescale 1ns/1ps
module tcc_pin_model (
	input wire logic pin_out, // block level
	input wire logic pin_oe, // block drive
	input wire logic ext_level, // outside level
	output logic pin_in // wire level
);
	// block drive wins, so no stale outside level leaks into compare
	assign pin_in = pin_oe ? pin_out : ext_level;
endmodule : tcc_pin_model

// [verif/tcc_top_properties.sv]
/* tcc_top_properties: port checks of tcc_top.
 * Assumes writes commit at the edge where pready is high. */
`timescale 1ns/1ps
module tcc_top_properties (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic pwrite, // apb
	input wire logic [tcc_pkg::ADDR_W-1:0] paddr, // apb
	input wire logic [31:0] pwdata, // apb
	input wire logic [31:0] prdata, // apb
	input wire logic pready, // apb
	input wire logic pslverr, // apb
	input wire logic compare_match, // match
	input wire logic pin_out, // pin
	input wire logic pin_oe // pin drive
);
	import tcc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] sel_q;
	logic wr_sel;
	logic cm_ok;
	assign wr_sel = psel && penable && pready && pwrite
		&& paddr == OFS_IO_SELECT;
	// a match in a select write cycle is ignored
	assign cm_ok = compare_match && !wr_sel && !sel_q[SEL_BIT3];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= 4'h0;
		end else if (wr_sel) begin
			sel_q <= pwdata[3:0];
		end
	end
	property p_apb_wait;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("pready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready held");
	property p_err_read;
		pslverr && !pwrite |-> pready && prdata == 32'h0;
	endproperty
	a_err_read: assert property (p_err_read)
		else $error("bad error read");
	property p_cmp_low;
		cm_ok && sel_q[1:0] == OC_LOW |=> !pin_out;
	endproperty
	a_cmp_low: assert property (p_cmp_low)
		else $error("pin not low");
	property p_cmp_high;
		cm_ok && sel_q[1:0] == OC_HIGH |=> pin_out;
	endproperty
	a_cmp_high: assert property (p_cmp_high)
		else $error("pin not high");
	property p_cmp_toggle;
		cm_ok && sel_q[1:0] == OC_TOGGLE |=> pin_out != $past(pin_out);
	endproperty
	a_cmp_toggle: assert property (p_cmp_toggle)
		else $error("pin not toggled");
	property p_init_level;
		wr_sel && !pwdata[3] && pwdata[1:0] != OC_DISABLED
			|=> pin_oe && pin_out == $past(pwdata[SEL_BIT2]);
	endproperty
	a_init_level: assert property (p_init_level)
		else $error("bad initial level");
	property p_no_drive;
		wr_sel && (pwdata[3] || pwdata[1:0] == OC_DISABLED) |=> !pin_oe;
	endproperty
	a_no_drive: assert property (p_no_drive)
		else $error("pin driven");
endmodule : tcc_top_properties
bind tcc_top tcc_top_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.compare_match(compare_match), .pin_out(pin_out), .pin_oe(pin_oe));

// [verif/tcc_top_test.sv]
/* tcc_top_test: compare table, capture modes, contention, registers.
 * Assumes the one wait state APB slave of tcc_top. */
`timescale 1ns/1ps
module tcc_top_test;
	import tcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [CNT_W-1:0] cnt, r, f;
	logic cm, ch3, pin_in, pin_out, pin_oe, ext;
	int error_cnt, n_tests, cyc;
	// select, oe, initial level, level after first and second match
	logic [7:0] tbl [8] = '{8'h00, 8'h18, 8'h2B, 8'h3A, 8'h40, 8'h5C,
		8'h6F, 8'h7D};
	tcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_value(cnt), .compare_match(cm),
		.ch3_event(ch3), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));
	tcc_pin_model u_pin (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext), .pin_in(pin_in));
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic pulse(logic on_ch3);
		if (on_ch3) begin
			ch3 <= 1'b1;
		end else begin
			cm <= 1'b1;
		end
		@(posedge pclk);
		cm <= 1'b0;
		ch3 <= 1'b0;
		@(posedge pclk);
	endtask : pulse
	task automatic cap(logic lv, logic [15:0] c, logic [15:0] e);
		cnt <= c;
		ext <= lv;
		repeat (6) @(posedge pclk);
		apb(1'b0, OFS_GEN_REG_A, 32'h0);
		chk("capture", rd, {16'h0, e});
	endtask : cap
	// hits the write commit edge with a channel 3 capture
	task automatic clash(logic [ADDR_W-1:0] a, logic [15:0] c);
		cnt <= c;
		fork
			apb(1'b1, a, 32'h5A5B);
			begin
				repeat (2) @(posedge pclk);
				pulse(1'b1);
			end
		join
	endtask : clash
	task automatic finish_test();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			finish_test();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, cm, ch3, ext} = '0;
		paddr = '0;
		pwdata = '0;
		cnt = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("oe", pin_oe, 0);
		foreach (tbl[i]) begin
			apb(1'b1, OFS_IO_SELECT, {28'h0, tbl[i][7:4]});
			chk("oe", pin_oe, tbl[i][3]);
			chk("init", pin_out, tbl[i][2]);
			for (int k = 1; k >= 0; k--) begin
				pulse(1'b0);
				chk("match", pin_out, tbl[i][k]);
			end
		end
		for (int s = 8; s < 13; s++) begin
			ext <= 1'b0;
			apb(1'b1, OFS_IO_SELECT, s);
			repeat (4) @(posedge pclk);
			apb(1'b1, OFS_GEN_REG_A, 32'h1234);
			r = (s == 8 || s[3:1] == 3'h5) ? 16'hA001 : 16'h1234;
			cap(1'b1, 16'hA001, r);
			f = (s == 9 || s[3:1] == 3'h5) ? 16'hB002 : r;
			cap(1'b0, 16'hB002, f);
		end
		cnt <= 16'hC003;
		pulse(1'b1);
		cap(1'b0, 16'hC003, 16'hC003);
		clash(OFS_GEN_REG_A, 16'hD004);
		apb(1'b0, OFS_GEN_REG_A, 32'h0);
		chk("rega", rd, 32'h0000D004);
		apb(1'b1, OFS_CONTROL, 32'h1);
		clash(OFS_BUFFER, 16'hE005);
		apb(1'b0, OFS_BUFFER, 32'h0);
		chk("buffer", rd, 32'h0000D004);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", er, 1);
		chk("unmapped", rd, 0);
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk("control", rd, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, 32'h3);
		apb(1'b1, OFS_STATUS, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("cleared", rd, 32'h2);
		// capture and flag clear in one commit cycle: the set wins
		clash(OFS_STATUS, 16'hF006);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("set wins", rd, 32'h3);
		apb(1'b0, OFS_BUFFER, 32'h0);
		chk("transfer", rd, 32'h0000E005);
		apb(1'b0, OFS_GEN_REG_A, 32'h0);
		chk("ch3 capture", rd, 32'h0000F006);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("reset oe", pin_oe, 0);
		chk("reset pin", pin_out, 0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_GEN_REG_A, 32'h0);
		chk("reset rega", rd, 32'h0000FFFF);
		apb(1'b0, OFS_BUFFER, 32'h0);
		chk("reset buffer", rd, 32'h0000FFFF);
		apb(1'b0, OFS_IO_SELECT, 32'h0);
		chk("reset select", rd, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("reset status", rd, 32'h0);
		finish_test();
	end
endmodule : tcc_top_test
